// >>> sphpb_regs.svh
// Purpose: constants for the host port bridge
// Assumes: 20 MHz core clock
// Notes:   frame fields, address decode and timing counts
`ifndef SPHPB_REGS_SVH
`define SPHPB_REGS_SVH
`define SPHPB_FRAME_BITS   29
`define SPHPB_CNT_W        5
`define SPHPB_BIT_RW       28
`define SPHPB_ADDR_HI      27
`define SPHPB_ADDR_LO      16
`define SPHPB_BIT_BUSY     15
`define SPHPB_BIT_NACK     13
`define SPHPB_BIT_REJECT   12
`define SPHPB_PORTS        4
`define SPHPB_LOCAL_PAGE   4'h8
`define SPHPB_ALL_ONES     29'h1FFFFFFF
`define SPHPB_CLK_MHZ      20
`define SPHPB_LOCAL_GAP_US 1
`define SPHPB_LOCAL_GAP_CYC (`SPHPB_LOCAL_GAP_US * `SPHPB_CLK_MHZ)
`endif

// >>> sphpb_pkg.sv
// Purpose: types for the host port bridge
// Assumes: nothing
// Notes:   one-hot frame engine states
package sphpb_pkg;
	typedef enum logic [2:0] {
		SPHPB_IDLE  = 3'b001,
		SPHPB_SHIFT = 3'b010,
		SPHPB_ACT   = 3'b100
	} sphpb_state_t;
endpackage

// >>> sphpb_port_if.sv
// Purpose: carries one downstream request/answer between bridge and port tracker
// Assumes: single clock
// Notes:   none
`timescale 1ns/100ps
interface sphpb_port_if;
	logic       reqValid;
	logic       reqRead;
	logic [7:0] reqOffset;
	logic [7:0] reqData;
	logic       busy;
	logic       doneValid;
	logic [7:0] doneData;
	logic       doneNack;
	logic [7:0] heldData;
	logic       heldNack;
	modport bridge (output reqValid, reqRead, reqOffset, reqData,
		input busy, heldData, heldNack, doneValid, doneData, doneNack);
	modport tracker (input reqValid, reqRead, reqOffset, reqData, doneValid, doneData,
		doneNack, output busy, heldData, heldNack);
endinterface

// >>> sphpb_port_track.sv
// Purpose: per-port busy tracker between bridge and one downstream master
// Assumes: master reports completion by doneValid pulse
// Notes:   the set of busy wins over a completion in the same cycle
`timescale 1ns/100ps
module sphpb_port_track (
	input  wire logic   clk,
	input  wire logic   rst,
	sphpb_port_if.tracker pif
);
	logic busyReg;
	logic [7:0] dataReg;
	logic nackReg;
	assign pif.busy     = busyReg;
	assign pif.heldData = dataReg;
	assign pif.heldNack = nackReg;
	// busy from issue until the master reports back (RULE_21)
	always_ff @(posedge clk) begin
		if (rst) begin
			busyReg <= 1'b0;
		end else if (pif.reqValid) begin
			busyReg <= 1'b1;
		end else if (pif.doneValid) begin
			busyReg <= 1'b0;
		end
	end
	// result of last completed access
	always_ff @(posedge clk) begin
		if (rst) begin
			dataReg <= 8'h00;
			nackReg <= 1'b0;
		end else if (pif.doneValid) begin
			dataReg <= pif.doneData;
			nackReg <= pif.doneNack;
		end
	end
endmodule

// >>> spi_host_port_bridge.sv
// Purpose: host-side SPI slave that reaches local registers and four downstream masters
// Assumes: spi mode 0, sck sampled by clk; downstream masters live outside
// Notes:   all pin inputs pass two flip-flops; reads take two frames
// How it works
// (RULE_01) each frame is 29 bits framed by low select; acted on at select rise
// (RULE_02) bit 28 read flag, 27:16 address, 15 busy, 13 nack, 12 reject, 7:0 data
// (RULE_03) while a frame shifts in, the previous frame's response shifts out
// (RULE_04) a read uses two frames; the second returns the fetched data
// (RULE_05) between frames the byte is fetched locally or downstream by address
// (RULE_06) host leaves select high at least 1 us between local read frames
// (RULE_07) host waits 170 or 620 us between downstream read frames on a port
// (RULE_08) a downstream read becomes an i2c read request on that port
// (RULE_09) an all-ones frame is invalid and does nothing
// (RULE_10) any second frame still returns valid data of the previous read
// (RULE_11) reading a local register clears its self-clearing bits
// (RULE_12) host should use an all-ones dummy frame after a local read
// (RULE_13) downstream read response reports port busy in the top data bit
// (RULE_14) an early second frame shows busy set to one
// (RULE_15) a read to a busy port is refused and reported with reject set
// (RULE_16) a write completes in one frame
// (RULE_17) writes to different ports may follow with minimal spacing
// (RULE_18) host waits the access delay before writing the same port again
// (RULE_19) only one host interface is active, chosen by the protocol select pin
// (RULE_20) each downstream port has its own independent master
// (RULE_21) busy and reject are tracked per port
`timescale 1ns/100ps
`include "sphpb_regs.svh"
module spi_host_port_bridge (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        host_protocol_select,
	input  wire logic        sck,
	input  wire logic        selectN,
	input  wire logic        mosi,
	output logic             miso,
	output logic             misoOe,
	output logic             locValid,
	output logic             locRead,
	output logic [7:0]       locAddr,
	output logic [7:0]       locWrData,
	input  wire logic [7:0]  locRdData,
	output logic [3:0]       dnReqValid,
	output logic [3:0]       dnReqRead,
	output logic [7:0]       dnReqDevice,
	output logic [7:0]       dnReqOffset,
	output logic [7:0]       dnReqData,
	input  wire logic [3:0]  dnDoneValid,
	input  wire logic [31:0] dnDoneData,
	input  wire logic [3:0]  dnDoneNack,
	output logic [3:0]       portBusy
);
	logic [1:0] sckSync;
	logic [1:0] selSync;
	logic [1:0] mosiSync;
	logic [1:0] protoSync;
	logic       sckLast;
	logic       selLast;
	sphpb_pkg::sphpb_state_t stateReg;
	logic [`SPHPB_FRAME_BITS-1:0] shiftIn;
	logic [`SPHPB_FRAME_BITS-1:0] shiftOut;
	logic [`SPHPB_FRAME_BITS-1:0] respReg;
	logic [`SPHPB_CNT_W-1:0]      bitCnt;
	logic [3:0] portBusyW;
	logic [7:0] heldData [`SPHPB_PORTS];
	logic [3:0] heldNack;
	logic [3:0] reqValidW;
	logic spiOn;
	logic sckRise;
	logic sckFall;
	logic selFall;
	logic selRise;
	logic frameRead;
	logic [11:0] frameAddr;
	logic [3:0] page;
	logic isLocal;
	logic isDown;
	logic [1:0] portIdx;
	logic frameOk;
	logic       pendDnRead;
	logic [1:0] pendPort;
	logic [`SPHPB_FRAME_BITS-1:0] loadWord;
	// two-stage synchronisers; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			sckSync   <= 2'h0;
			selSync   <= 2'h3;
			mosiSync  <= 2'h0;
			protoSync <= 2'h0;
		end else begin
			sckSync   <= {sckSync[0], sck};
			selSync   <= {selSync[0], selectN};
			mosiSync  <= {mosiSync[0], mosi};
			protoSync <= {protoSync[0], host_protocol_select};
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			sckLast <= 1'b0;
			selLast <= 1'b1;
		end else begin
			sckLast <= sckSync[1];
			selLast <= selSync[1];
		end
	end
	// spi is used only when the select pin is high (RULE_19)
	assign spiOn     = protoSync[1];
	assign sckRise   = sckSync[1] & ~sckLast;
	assign sckFall   = ~sckSync[1] & sckLast;
	assign selFall   = ~selSync[1] & selLast;
	assign selRise   = selSync[1] & ~selLast;
	assign frameRead = shiftIn[`SPHPB_BIT_RW]; // RULE_02
	assign frameAddr = shiftIn[`SPHPB_ADDR_HI:`SPHPB_ADDR_LO]; // RULE_02
	assign page      = frameAddr[11:8];
	assign portIdx   = page[2:1];
	assign isLocal   = (page == `SPHPB_LOCAL_PAGE);
	assign isDown    = ~page[3];
	// exact length and not the all-ones dummy (RULE_01) (RULE_09)
	assign frameOk   = (bitCnt == 5'(`SPHPB_FRAME_BITS)) && (shiftIn != `SPHPB_ALL_ONES);
	// one tracker per port, each beside its own master (RULE_20)
	genvar g;
	generate
		for (g = 0; g < `SPHPB_PORTS; g++) begin : gPort
			sphpb_port_if pif ();
			assign pif.reqValid  = reqValidW[g];
			assign pif.reqRead   = frameRead;
			assign pif.reqOffset = frameAddr[7:0];
			assign pif.reqData   = shiftIn[7:0];
			assign pif.doneValid = dnDoneValid[g];
			assign pif.doneData  = dnDoneData[8*g +: 8];
			assign pif.doneNack  = dnDoneNack[g];
			assign portBusyW[g]  = pif.busy;
			assign heldData[g]   = pif.heldData;
			assign heldNack[g]   = pif.heldNack;
			sphpb_port_track uTrack (
				.clk (clk),
				.rst (rst),
				.pif (pif)
			);
			// issue only when this port is idle; others unaffected (RULE_15) (RULE_21) (RULE_17)
			assign reqValidW[g] = (stateReg == sphpb_pkg::SPHPB_ACT) && frameOk && isDown
				&& (portIdx == 2'(g)) && ~portBusyW[g];
		end
	endgenerate
	// frame engine
	always_ff @(posedge clk) begin
		if (rst) begin
			stateReg <= sphpb_pkg::SPHPB_IDLE;
		end else begin
			case (stateReg)
				sphpb_pkg::SPHPB_IDLE: begin
					if (spiOn && selFall) begin
						stateReg <= sphpb_pkg::SPHPB_SHIFT;
					end
				end
				sphpb_pkg::SPHPB_SHIFT: begin
					if (selRise) begin
						stateReg <= sphpb_pkg::SPHPB_ACT; // RULE_01
					end
				end
				sphpb_pkg::SPHPB_ACT: begin
					stateReg <= sphpb_pkg::SPHPB_IDLE;
				end
				default: begin
					stateReg <= sphpb_pkg::SPHPB_IDLE;
				end
			endcase
		end
	end
	// shift in msb first on sck rise, saturating bit count
	always_ff @(posedge clk) begin
		if (rst) begin
			shiftIn <= 29'h00000000;
			bitCnt  <= 5'h00;
		end else if (stateReg == sphpb_pkg::SPHPB_IDLE && selFall) begin
			bitCnt <= 5'h00;
		end else if (stateReg == sphpb_pkg::SPHPB_SHIFT && sckRise) begin
			shiftIn <= {shiftIn[`SPHPB_FRAME_BITS-2:0], mosiSync[1]};
			if (bitCnt != 5'h1F) begin
				bitCnt <= bitCnt + 5'h01;
			end
		end
	end
	// response built at frame end, shown in the next frame (RULE_03) (RULE_10)
	always_ff @(posedge clk) begin
		if (rst) begin
			respReg    <= 29'h00000000;
			pendDnRead <= 1'b0;
			pendPort   <= 2'h0;
		end else if (stateReg == sphpb_pkg::SPHPB_ACT && frameOk) begin
			respReg    <= {shiftIn[28:16], 16'h0000};
			pendDnRead <= isDown && frameRead && ~portBusyW[portIdx];
			pendPort   <= portIdx;
			if (isLocal && frameRead) begin
				respReg[7:0] <= locRdData; // RULE_05 RULE_11
			end else if (isDown) begin
				respReg[`SPHPB_BIT_BUSY]   <= portBusyW[portIdx]; // RULE_13 RULE_14
				respReg[`SPHPB_BIT_REJECT] <= portBusyW[portIdx]; // RULE_15
				respReg[`SPHPB_BIT_NACK]   <= heldNack[portIdx];
				respReg[7:0]               <= heldData[portIdx]; // RULE_04
			end
		end else if (stateReg == sphpb_pkg::SPHPB_ACT && isDown && frameRead == 1'b0) begin
			respReg <= respReg;
		end
	end
	// accepted downstream read: busy and data taken at load, not at issue (RULE_14) (RULE_04)
	always_comb begin
		loadWord = respReg;
		if (pendDnRead) begin
			loadWord[`SPHPB_BIT_BUSY] = portBusyW[pendPort]; // RULE_13
			loadWord[`SPHPB_BIT_NACK] = heldNack[pendPort];
			loadWord[7:0]             = heldData[pendPort];
		end
	end
	// miso: load response at select fall, shift on sck fall; enabled while selected
	always_ff @(posedge clk) begin
		if (rst) begin
			shiftOut <= 29'h00000000;
			miso     <= 1'b0;
			misoOe   <= 1'b0;
		end else begin
			misoOe <= spiOn && ~selSync[1];
			if (stateReg == sphpb_pkg::SPHPB_IDLE && selFall) begin
				shiftOut <= {loadWord[`SPHPB_FRAME_BITS-2:0], 1'b0};
				miso     <= loadWord[`SPHPB_BIT_RW]; // RULE_03
			end else if (stateReg == sphpb_pkg::SPHPB_SHIFT && sckFall) begin
				shiftOut <= {shiftOut[`SPHPB_FRAME_BITS-2:0], 1'b0};
				miso     <= shiftOut[`SPHPB_FRAME_BITS-1];
			end
		end
	end
	// local access strobe: one cycle, write completes in one frame (RULE_16) (RULE_05)
	always_ff @(posedge clk) begin
		if (rst) begin
			locValid  <= 1'b0;
			locRead   <= 1'b0;
			locAddr   <= 8'h00;
			locWrData <= 8'h00;
		end else begin
			locValid  <= (stateReg == sphpb_pkg::SPHPB_SHIFT) && selRise && isLocal
				&& (bitCnt == 5'(`SPHPB_FRAME_BITS)) && (shiftIn != `SPHPB_ALL_ONES);
			locRead   <= frameRead;
			locAddr   <= frameAddr[7:0];
			locWrData <= shiftIn[7:0];
		end
	end
	// downstream request strobes, registered (RULE_08)
	always_ff @(posedge clk) begin
		if (rst) begin
			dnReqValid  <= 4'h0;
			dnReqRead   <= 4'h0;
			dnReqDevice <= 8'h00;
			dnReqOffset <= 8'h00;
			dnReqData   <= 8'h00;
			portBusy    <= 4'h0;
		end else begin
			dnReqValid  <= reqValidW;
			dnReqRead   <= {4{frameRead}} & reqValidW;
			dnReqDevice <= {4'hA, 2'h0, page[0], 1'b0};
			dnReqOffset <= frameAddr[7:0];
			dnReqData   <= shiftIn[7:0];
			portBusy    <= portBusyW;
		end
	end
	// refused read leaves the port busy and the master untouched
	a_reject_noissue: assert property (@(posedge clk) disable iff (rst)
		(stateReg == sphpb_pkg::SPHPB_ACT && frameOk && isDown && portBusyW[portIdx])
		|=> ##0 (dnReqValid == 4'h0) && respReg[`SPHPB_BIT_REJECT]) // RULE_15
		else $error("busy port request not refused");
	a_dummy_ignored: assert property (@(posedge clk) disable iff (rst)
		(stateReg == sphpb_pkg::SPHPB_ACT && shiftIn == `SPHPB_ALL_ONES)
		|=> (dnReqValid == 4'h0) && $stable(respReg)) // RULE_09
		else $error("dummy frame caused action");
	a_miso_off_idle: assert property (@(posedge clk) disable iff (rst)
		selSync[1] |=> !misoOe) // RULE_03
		else $error("miso driven while deselected");
	a_oe_while_sel: assert property (@(posedge clk) disable iff (rst) // RULE_03
		(spiOn && !selSync[1]) |=> misoOe)
		else $error("miso not driven while selected");
	a_busy_after_req: assert property (@(posedge clk) disable iff (rst) // RULE_21
		(dnReqValid != 4'h0) |=> ((portBusy & $past(dnReqValid)) == $past(dnReqValid)))
		else $error("issued port not marked busy");
	a_loc_one_pulse: assert property (@(posedge clk) disable iff (rst) // RULE_16
		locValid |=> !locValid)
		else $error("local strobe longer than one cycle");
endmodule

// >>> sphpb_far_model.sv
// Purpose: local byte source and four downstream masters
// Assumes: one clock, fixed fetch time
// Notes:   never nacks
`timescale 1ns/100ps
module sphpb_far_model #(parameter int LAT = 300) (
	input  wire logic        clk,
	input  wire logic [7:0]  locAddr,
	output logic [7:0]       locRdData,
	input  wire logic [3:0]  dnReqValid,
	input  wire logic [7:0]  dnReqOffset,
	output logic [3:0]       dnDoneValid = '0,
	output logic [31:0]      dnDoneData = '0,
	output logic [3:0]       dnDoneNack = '0
);
	int cnt [4] = '{0, 0, 0, 0};
	// local byte is a pure function of its address
	assign locRdData = locAddr ^ 8'h5A;
	// one master per port, each with its own countdown
	always @(posedge clk) begin
		for (int g = 0; g < 4; g++) begin
			dnDoneValid[g] <= cnt[g] == 1;
			if (dnReqValid[g]) begin
				cnt[g] <= LAT;
				dnDoneData[8*g +: 8] <= dnReqOffset ^ 8'hC3;
			end else if (cnt[g] > 0) begin
				cnt[g] <= cnt[g] - 1;
			end
		end
	end
endmodule

// >>> spi_host_port_bridge_tb.sv
// Purpose: self-checking bench for the host port bridge
// Assumes: spi mode 0, sck 400 ns
// Notes:   downstream data is compared once, after the full fetch wait
`timescale 1ns/100ps
module spi_host_port_bridge_tb;
	localparam logic [28:0] ONES = 29'h1FFFFFFF;
	logic        clk = 0, rst = 1, psel = 1, sck = 0, selectN = 1, mosi = 0;
	logic        miso, misoOe, locValid, locRead;
	logic [7:0]  locAddr, locWrData, locRdData, dnReqDevice, dnReqOffset, dnReqData;
	logic [3:0]  dnReqValid, dnReqRead, dnDoneValid, dnDoneNack, portBusy;
	logic [31:0] dnDoneData;
	logic [28:0] rx, lastReq;
	logic [16:0] lastLoc;
	int          errorCnt = 0, checksDone = 0, nReq = 0, nLoc = 0;

	always #25 clk = ~clk;

	spi_host_port_bridge dut (.clk, .rst, .host_protocol_select(psel), .sck, .selectN,
		.mosi, .miso, .misoOe, .locValid, .locRead, .locAddr, .locWrData, .locRdData,
		.dnReqValid, .dnReqRead, .dnReqDevice, .dnReqOffset, .dnReqData, .dnDoneValid,
		.dnDoneData, .dnDoneNack, .portBusy);
	sphpb_far_model #(.LAT(300)) far (.clk, .locAddr, .locRdData, .dnReqValid,
		.dnReqOffset, .dnDoneValid, .dnDoneData, .dnDoneNack);

	// record the last request pulse seen on either side
	always @(posedge clk) begin
		if (dnReqValid != 0) begin
			nReq++;
			lastReq = {dnReqValid, |dnReqRead, dnReqDevice, dnReqOffset, dnReqData};
		end
		if (locValid) begin
			nLoc++;
			lastLoc = {locRead, locAddr, locWrData};
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			errorCnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one whole frame; miso read just before each sck rise
	task automatic frame(input logic [28:0] tx, input int gap);
		selectN <= 0;
		cyc(4);
		for (int i = 28; i >= 0; i--) begin
			mosi <= tx[i];
			cyc(3);
			@(negedge clk) rx[i] = miso;
			if (i == 28) chk(misoOe, psel);
			@(posedge clk) sck <= 1;
			cyc(4);
			sck <= 0;
		end
		cyc(4);
		selectN <= 1;
		mosi <= ~tx[0]; // idle line must not hold the last bit
		cyc(gap);
		chk(misoOe, 1'b0);
	endtask

	task automatic results();
		if (errorCnt == 0 && checksDone > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// watchdog well beyond the planned run
	initial begin
		cyc(60000);
		errorCnt++;
		results();
	end

	initial begin
		logic [11:0] a;
		logic [7:0]  d;
		logic [1:0]  p;
		int          n;
		void'($urandom(14));
		cyc(12);
		rst <= 0;
		cyc(4);
		// local read, then two dummy frames
		repeat (3) begin
			a = {4'h8, 8'($urandom)};
			frame({1'b1, a, 16'h0000}, 40);
			chk(lastLoc[16:8], {1'b1, a[7:0]});
			n = nLoc;
			frame(ONES, 40);
			chk(rx, {1'b1, a, 8'h00, a[7:0] ^ 8'h5A});
			frame(ONES, 40);
			chk(rx, {1'b1, a, 8'h00, a[7:0] ^ 8'h5A});
			chk(nLoc, n);
		end
		// local write in one frame
		a = {4'h8, 8'($urandom)};
		d = 8'($urandom);
		frame({1'b0, a, 8'h00, d}, 40);
		chk(lastLoc, {1'b0, a[7:0], d});
		// spi off: frame ignored
		psel <= 0;
		cyc(4);
		n = nLoc;
		frame({1'b1, a, 16'h0000}, 40);
		chk(nLoc, n);
		psel <= 1;
		cyc(4);
		// downstream read, early repeat, write elsewhere meanwhile
		p = 2'($urandom);
		a = {1'b0, p, 1'($urandom), 8'($urandom)};
		frame({1'b1, a, 16'h0000}, 40);
		chk(lastReq[28:8], {4'b0001 << p, 1'b1, 4'hA, 2'b00, a[8], 1'b0, a[7:0]});
		chk(portBusy[p], 1);
		n = nReq;
		frame({1'b1, a, 16'h0000}, 40);
		chk({rx[28:15], rx[12]}, {1'b1, a, 2'b10});
		chk(nReq, n);
		d = 8'($urandom);
		frame({1'b0, 1'b0, p + 2'd1, 9'h000, 8'h00, d}, 40);
		chk(lastReq, {4'b0001 << (p + 2'd1), 1'b0, 8'hA0, 8'h00, d});
		chk({rx[15], rx[12]}, 2'b11);
		cyc(400);
		chk(portBusy, 4'h0);
		// writes to all ports back to back
		for (int g = 0; g < 4; g++) begin
			d = 8'($urandom);
			frame({1'b0, 1'b0, 2'(g), 9'h000, 8'h00, d}, 20);
			chk(lastReq, {4'b0001 << g, 1'b0, 8'hA0, 8'h00, d});
		end
		cyc(400);
		frame({1'b1, a, 16'h0000}, 40);
		chk(nReq, n + 6);
		cyc(3400);
		frame(ONES, 40);
		chk(rx, {1'b1, a, 8'h00, a[7:0] ^ 8'hC3});
		results();
	end
endmodule
